// [hdl/stp_pkg.sv]
/*
 * Shared constants of the serial temperature readout port: frame layout,
 * control word layout, reset values and timing counts.
 * Assumes a 125 MHz ref_clk on both ends of the link.
 */
package stp_pkg;

    localparam int          CLK_PERIOD_NS   = 8;
    localparam logic [4:0]  FRAME_LEN       = 5'h10;
    localparam int          RESULT_W        = 10;
    localparam int          CTRL_W          = 16;
    localparam int          PAD_BITS        = 6;
    localparam logic        PAD_LEVEL       = 1'h0;
    localparam int          PD_BIT          = 13;
    localparam logic [4:0]  LATCH_EDGE      = 5'h0F;
    localparam logic [9:0]  RESULT_RESET    = 10'h000;
    localparam logic [15:0] CTRL_RESET      = 16'h0000;

    // Conversion time is a typical figure; it is rounded up to whole cycles.
    localparam int          CONV_TIME_US    = 25;
    localparam int          CONV_CYCLES     = (CONV_TIME_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int          PERIOD_TIME_US  = 400;
    localparam int          PERIOD_CYCLES   = (PERIOD_TIME_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

    // Host link timing in ref_clk cycles; SPLIT_POINT is a bit count.
    localparam logic [4:0]  HALF_CYCLES     = 5'h06;
    localparam logic [4:0]  LEAD_CYCLES     = 5'h08;
    localparam logic [4:0]  TAIL_CYCLES     = 5'h08;
    localparam logic [4:0]  GAP_CYCLES      = 5'h10;
    localparam logic [4:0]  PAUSE_CYCLES    = 5'h10;
    localparam logic [4:0]  SPLIT_POINT     = 5'h08;

endpackage

// [hdl/stp_if.sv]
/*
 * Four-wire link between the serial master and the temperature port.
 * The data output is resolved here: an undriven line reads low.
 */
`timescale 1ns/10ps
interface stp_if;
    logic cs_n;      // Select, active low.
    logic sclk;      // Serial clock from the master.
    logic din;       // Master to device data.
    logic dout_o;    // Device output value.
    logic dout_oe;   // Device drives the output line.
    logic dout_line; // Resolved output line level.

    assign dout_line = dout_oe & dout_o;

    modport dev (input cs_n, input sclk, input din, output dout_o, output dout_oe);
    modport host (output cs_n, output sclk, output din, input dout_line);
endinterface // stp_if

// [hdl/stp_device.sv]
/*
 * Device end: serial readout port plus a small conversion sequencer.
 * The link logic runs on sclk with cs_n as its reset; the sequencer and the
 * registers live on ref_clk. Assumes the master keeps the result stable
 * window (a few ref_clk cycles after cs_n falls) before its first sclk edge.
 */
`timescale 1ns/10ps
module stp_device #(
    parameter int CONV_PERIOD_CYCLES = stp_pkg::PERIOD_CYCLES
) (
    stp_if.dev               link,               // Serial link, device side.
    input  wire logic        ref_clk,            // System clock, 125 MHz.
    input  wire logic        sys_rst,            // Synchronous reset, active high.
    input  wire logic [9:0]  temp_in,            // Converter code, two's complement.
    output logic      [9:0]  temperature_result, // Latest result.
    output logic             power_down,         // Shutdown in force.
    output logic             result_valid,       // At least one conversion done.
    output logic             converting          // Conversion in progress.
);

    typedef enum logic [2:0] {
        ST_CONV = 3'b001,
        ST_WAIT = 3'b010,
        ST_OFF  = 3'b100
    } stp_conv_type;

    // Link domain, clocked by sclk and held in reset while cs_n is high.
    logic [4:0]  fall_cnt_reg;
    logic [4:0]  fall_cnt_next;
    logic        dout_reg;
    logic        dout_next;
    logic        latched_reg;
    logic        latched_next;
    logic [15:0] ctrl_word_reg;
    logic [15:0] ctrl_word_next;
    logic [15:0] shift_in_reg;
    logic [15:0] shift_in_next;
    logic [15:0] frame_word;
    logic [3:0]  bit_idx;

    // System domain.
    logic        cs_s1_reg;
    logic        cs_s2_reg;
    logic        cs_s3_reg;
    logic        cs_stable_reg;
    logic        cs_stable_next;
    logic        lf_s1_reg;
    logic        lf_s2_reg;
    logic        lf_s3_reg;
    logic        lf_stable_reg;
    logic        lf_stable_next;
    logic        frame_end;
    logic        load_ctrl;
    logic [15:0] power_control_reg;
    logic [15:0] power_control_next;
    logic [9:0]  result_reg;
    logic [9:0]  result_next;
    logic        valid_reg;
    logic        valid_next;
    logic [15:0] timer_reg;
    logic [15:0] timer_next;
    stp_conv_type state_reg;
    stp_conv_type state_next;

    // The result word is only read while the sequencer holds it still, which
    // it does for as long as the synchronised select is low.
    assign frame_word = {result_reg, {stp_pkg::PAD_BITS{stp_pkg::PAD_LEVEL}}};
    assign bit_idx    = 4'(stp_pkg::FRAME_LEN - 5'h01) - fall_cnt_reg[3:0];

    always_comb begin
        fall_cnt_next  = fall_cnt_reg;
        dout_next      = dout_reg;
        latched_next   = latched_reg;
        ctrl_word_next = ctrl_word_reg;
        if (fall_cnt_reg < stp_pkg::FRAME_LEN) begin
            fall_cnt_next = fall_cnt_reg + 5'h01;
            dout_next     = frame_word[bit_idx];
        end
        if (fall_cnt_reg == stp_pkg::LATCH_EDGE - 5'h01) begin
            latched_next   = 1'h1;
            // Fourteen bits are in by now; align them to frame positions.
            ctrl_word_next = {shift_in_reg[13:0], 2'h0};
        end
    end

    // A high select resets the link logic, so sclk edges do nothing then.
    always_ff @(negedge link.sclk or posedge link.cs_n) begin
        if (link.cs_n) begin
            fall_cnt_reg  <= 5'h00;
            dout_reg      <= stp_pkg::PAD_LEVEL;
            latched_reg   <= 1'h0;
            ctrl_word_reg <= stp_pkg::CTRL_RESET;
        end else begin
            fall_cnt_reg  <= fall_cnt_next;
            dout_reg      <= dout_next;
            latched_reg   <= latched_next;
            ctrl_word_reg <= ctrl_word_next;
        end
    end

    always_comb begin
        shift_in_next = {shift_in_reg[14:0], link.din};
    end

    always_ff @(posedge link.sclk or posedge link.cs_n) begin
        if (link.cs_n) begin
            shift_in_reg <= stp_pkg::CTRL_RESET;
        end else begin
            shift_in_reg <= shift_in_next;
        end
    end

    assign link.dout_o  = dout_reg;
    assign link.dout_oe = ~link.cs_n;

    // Pins entering ref_clk pass three stages; a change counts once the last
    // two agree. The latch flag is a level held until the frame ends.
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            cs_s1_reg <= 1'h1;
            cs_s2_reg <= 1'h1;
            cs_s3_reg <= 1'h1;
            lf_s1_reg <= 1'h0;
            lf_s2_reg <= 1'h0;
            lf_s3_reg <= 1'h0;
        end else begin
            cs_s1_reg <= link.cs_n;
            cs_s2_reg <= cs_s1_reg;
            cs_s3_reg <= cs_s2_reg;
            lf_s1_reg <= latched_reg;
            lf_s2_reg <= lf_s1_reg;
            lf_s3_reg <= lf_s2_reg;
        end
    end

    always_comb begin
        cs_stable_next = cs_stable_reg;
        lf_stable_next = lf_stable_reg;
        if (cs_s2_reg == cs_s3_reg) begin
            cs_stable_next = cs_s2_reg;
        end
        if (lf_s2_reg == lf_s3_reg) begin
            lf_stable_next = lf_s2_reg;
        end
        frame_end = ~cs_stable_reg & cs_stable_next;
        load_ctrl = ~lf_stable_reg & lf_stable_next;
        // The control word is quiet while the flag is up, so it is safe here.
        power_control_next = load_ctrl ? ctrl_word_reg : power_control_reg;
    end

    always_comb begin
        state_next  = state_reg;
        timer_next  = timer_reg + 16'h0001;
        result_next = result_reg;
        valid_next  = valid_reg;
        unique case (state_reg)
            ST_OFF: begin
                timer_next = 16'h0000;
                if (!power_control_next[stp_pkg::PD_BIT]) begin
                    state_next = ST_CONV;
                end
            end
            ST_CONV: begin
                if (power_control_next[stp_pkg::PD_BIT]) begin
                    state_next = ST_OFF;
                    timer_next = 16'h0000;
                end else if (frame_end) begin
                    timer_next = 16'h0000;
                end else if (timer_reg >= 16'(stp_pkg::CONV_CYCLES - 1)) begin
                    // Hold the finished code back while a frame is reading.
                    timer_next = timer_reg;
                    if (cs_stable_reg) begin
                        result_next = temp_in;
                        valid_next  = 1'h1;
                        state_next  = ST_WAIT;
                        timer_next  = 16'h0000;
                    end
                end
            end
            ST_WAIT: begin
                if (power_control_next[stp_pkg::PD_BIT]) begin
                    state_next = ST_OFF;
                    timer_next = 16'h0000;
                end else if (frame_end || timer_reg >= 16'(CONV_PERIOD_CYCLES - stp_pkg::CONV_CYCLES - 1)) begin
                    state_next = ST_CONV;
                    timer_next = 16'h0000;
                end
            end
            default: begin
                state_next = ST_CONV;
                timer_next = 16'h0000;
            end
        endcase
    end

    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            cs_stable_reg     <= 1'h1;
            lf_stable_reg     <= 1'h0;
            power_control_reg <= stp_pkg::CTRL_RESET;
            state_reg         <= ST_CONV;
            timer_reg         <= 16'h0000;
            result_reg        <= stp_pkg::RESULT_RESET;
            valid_reg         <= 1'h0;
        end else begin
            cs_stable_reg     <= cs_stable_next;
            lf_stable_reg     <= lf_stable_next;
            power_control_reg <= power_control_next;
            state_reg         <= state_next;
            timer_reg         <= timer_next;
            result_reg        <= result_next;
            valid_reg         <= valid_next;
        end
    end

    // The code is passed through untouched: 0.25 C per LSB, two's complement.
    assign temperature_result = result_reg;
    assign power_down         = power_control_reg[stp_pkg::PD_BIT];
    assign result_valid       = valid_reg;
    assign converting         = (state_reg == ST_CONV);

endmodule // stp_device

// [hdl/stp_host.sv]
/*
 * Master end: makes sclk from ref_clk by a divider, drives select and the
 * control word, and collects the sixteen returned bits.
 * Assumes the device end sits on the same interface instance.
 */
`timescale 1ns/10ps
module stp_host (
    stp_if.host              link,     // Serial link, master side.
    input  wire logic        ref_clk,  // System clock, 125 MHz.
    input  wire logic        sys_rst,  // Synchronous reset, active high.
    input  wire logic        start,    // Begin one frame, pulse.
    input  wire logic        pd_req,   // Power-down bit to send.
    input  wire logic        split,    // Send as two byte transfers.
    output logic             busy,     // Frame or gap in progress.
    output logic             done,     // Frame finished, pulse.
    output logic      [15:0] rd_word,  // Whole returned frame.
    output logic      [9:0]  rd_temp   // Result field of rd_word.
);

    typedef enum logic [5:0] {
        H_IDLE  = 6'b000001,
        H_LEAD  = 6'b000010,
        H_LOW   = 6'b000100,
        H_HIGH  = 6'b001000,
        H_PAUSE = 6'b010000,
        H_TAIL  = 6'b100000
    } stp_host_type;

    stp_host_type state_reg;
    stp_host_type state_next;
    logic [4:0]  tmr_reg;
    logic [4:0]  tmr_next;
    logic [4:0]  bit_reg;
    logic [4:0]  bit_next;
    logic [4:0]  gap_reg;
    logic [4:0]  gap_next;
    logic [15:0] tx_reg;
    logic [15:0] tx_next;
    logic [15:0] rx_reg;
    logic [15:0] rx_next;
    logic [15:0] rd_reg;
    logic [15:0] rd_next;
    logic        cs_n_reg;
    logic        cs_n_next;
    logic        sclk_reg;
    logic        sclk_next;
    logic        din_reg;
    logic        din_next;
    logic        done_reg;
    logic        done_next;
    logic        d1_reg;
    logic        d2_reg;
    logic        d3_reg;
    logic        d_stable_reg;
    logic        d_stable_next;

    always_comb begin
        state_next    = state_reg;
        tmr_next      = tmr_reg + 5'h01;
        bit_next      = bit_reg;
        gap_next      = (gap_reg != 5'h00) ? gap_reg - 5'h01 : gap_reg;
        tx_next       = tx_reg;
        rx_next       = rx_reg;
        rd_next       = rd_reg;
        cs_n_next     = cs_n_reg;
        sclk_next     = sclk_reg;
        din_next      = din_reg;
        done_next     = 1'h0;
        d_stable_next = (d2_reg == d3_reg) ? d2_reg : d_stable_reg;
        unique case (state_reg)
            H_IDLE: begin
                tmr_next  = 5'h00;
                sclk_next = 1'h1;
                if (start && gap_reg == 5'h00) begin
                    // Only the power-down position may carry a one.
                    tx_next    = 16'(pd_req) << stp_pkg::PD_BIT;
                    cs_n_next  = 1'h0;
                    bit_next   = 5'h00;
                    state_next = H_LEAD;
                end
            end
            H_LEAD, H_PAUSE: begin
                if ((state_reg == H_LEAD && tmr_reg == stp_pkg::LEAD_CYCLES - 5'h01) ||
                    (state_reg == H_PAUSE && tmr_reg == stp_pkg::PAUSE_CYCLES - 5'h01)) begin
                    sclk_next  = 1'h0;
                    din_next   = tx_reg[4'(5'h0F - bit_reg)];
                    tmr_next   = 5'h00;
                    state_next = H_LOW;
                end
            end
            H_LOW: begin
                if (tmr_reg == stp_pkg::HALF_CYCLES - 5'h01) begin
                    sclk_next  = 1'h1;
                    rx_next    = {rx_reg[14:0], d_stable_reg};
                    bit_next   = bit_reg + 5'h01;
                    tmr_next   = 5'h00;
                    state_next = H_HIGH;
                end
            end
            H_HIGH: begin
                if (tmr_reg == stp_pkg::HALF_CYCLES - 5'h01) begin
                    tmr_next = 5'h00;
                    if (bit_reg == stp_pkg::FRAME_LEN) begin
                        state_next = H_TAIL;
                    end else if (split && bit_reg == stp_pkg::SPLIT_POINT) begin
                        state_next = H_PAUSE;
                    end else begin
                        sclk_next  = 1'h0;
                        din_next   = tx_reg[4'(5'h0F - bit_reg)];
                        state_next = H_LOW;
                    end
                end
            end
            H_TAIL: begin
                if (tmr_reg == stp_pkg::TAIL_CYCLES - 5'h01) begin
                    cs_n_next  = 1'h1;
                    din_next   = 1'h0;
                    rd_next    = rx_reg;
                    done_next  = 1'h1;
                    gap_next   = stp_pkg::GAP_CYCLES;
                    state_next = H_IDLE;
                end
            end
            default: begin
                state_next = H_IDLE;
            end
        endcase
    end

    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            state_reg    <= H_IDLE;
            tmr_reg      <= 5'h00;
            bit_reg      <= 5'h00;
            gap_reg      <= 5'h00;
            tx_reg       <= stp_pkg::CTRL_RESET;
            rx_reg       <= 16'h0000;
            rd_reg       <= 16'h0000;
            cs_n_reg     <= 1'h1;
            sclk_reg     <= 1'h1;
            din_reg      <= 1'h0;
            done_reg     <= 1'h0;
            d1_reg       <= 1'h0;
            d2_reg       <= 1'h0;
            d3_reg       <= 1'h0;
            d_stable_reg <= 1'h0;
        end else begin
            state_reg    <= state_next;
            tmr_reg      <= tmr_next;
            bit_reg      <= bit_next;
            gap_reg      <= gap_next;
            tx_reg       <= tx_next;
            rx_reg       <= rx_next;
            rd_reg       <= rd_next;
            cs_n_reg     <= cs_n_next;
            sclk_reg     <= sclk_next;
            din_reg      <= din_next;
            done_reg     <= done_next;
            d1_reg       <= link.dout_line;
            d2_reg       <= d1_reg;
            d3_reg       <= d2_reg;
            d_stable_reg <= d_stable_next;
        end
    end

    assign link.cs_n = cs_n_reg;
    assign link.sclk = sclk_reg;
    assign link.din  = din_reg;
    assign busy      = (state_reg != H_IDLE) || (gap_reg != 5'h00);
    assign done      = done_reg;
    assign rd_word   = rd_reg;
    assign rd_temp   = rd_reg[15:6];

endmodule // stp_host

// [verif/stp_link_props.sv]
/*
 * Assertion checker for the four-wire link between master and temperature port.
 * Takes the link signals, the system clock and its reset as plain inputs.
 */
`timescale 1ns/10ps
module stp_link_props (
    input wire logic ref_clk,   // System clock.
    input wire logic sys_rst,   // Synchronous reset, active high.
    input wire logic cs_n,      // Select, active low.
    input wire logic sclk,      // Serial clock.
    input wire logic din,       // Master data.
    input wire logic dout_o,    // Device data value.
    input wire logic dout_oe,   // Device output enable.
    input wire logic dout_line  // Resolved output line.
);
    logic       sclk_reg;
    logic [4:0] rise_reg;
    logic [4:0] fall_reg;

    // Edges are counted on ref_clk, which is far faster than the serial clock.
    always_ff @(posedge ref_clk) begin
        sclk_reg <= sclk;
        rise_reg <= cs_n ? 5'h00 : rise_reg + {4'h0, sclk & ~sclk_reg};
        fall_reg <= cs_n ? 5'h00 : fall_reg + {4'h0, ~sclk & sclk_reg};
    end

    default clocking @(posedge ref_clk); endclocking
    default disable iff (sys_rst);

    oe_tracks_select_a: assert property (dout_oe == !cs_n)
        else $error("output enable does not follow select");
    released_line_low_a: assert property (cs_n |-> !dout_oe && !dout_line)
        else $error("output line driven while deselected");
    edge_aligned_out_a: assert property (!cs_n && $changed(dout_o) |-> $fell(sclk))
        else $error("output changed away from a falling clock edge");
    pad_bits_zero_a: assert property (!cs_n && fall_reg >= 5'h0B |-> !dout_o)
        else $error("pad position not zero");
    last_bit_held_a: assert property (!cs_n && fall_reg == 5'h10 |-> $stable(dout_o))
        else $error("last bit not held");
    frame_length_a: assert property ($rose(cs_n) |-> rise_reg == 5'h10)
        else $error("frame not sixteen clocks");
    // The first two positions are free for the master; only those past the power-down bit must be zero.
    control_zero_bits_a: assert property (!cs_n && sclk && !sclk_reg && rise_reg >= 5'h03 |-> !din)
        else $error("nonzero control bit outside power-down position");
    select_lead_a: assert property ($fell(cs_n) |-> sclk [*8])
        else $error("clock started too soon after select");
    clock_low_phase_a: assert property ($fell(sclk) |-> !sclk [*6] ##1 sclk)
        else $error("low phase not six cycles");
    idle_clock_high_a: assert property (cs_n |-> sclk)
        else $error("clock not idle high");

    cover property ($rose(cs_n));
    cover property (!cs_n && sclk && !sclk_reg && rise_reg == 5'h02 && din);
    cover property ((!cs_n && rise_reg == 5'h08 && sclk) [*8]);
endmodule // stp_link_props

// [verif/serial_temp_readout_port_tb.sv]
/*
 * Self-checking bench: a master and a device joined on one link, plus a
 * second device driven directly by the bench to break the framing rules.
 * Assumes the design files under hdl/ are compiled first.
 */
`timescale 1ns/10ps
module serial_temp_readout_port_tb;
    localparam int CONV_PERIOD = 4000;
    localparam int TIME_LIMIT  = 60000;

    logic        ref_clk = 1'b0;
    logic        sys_rst = 1'b1;
    logic        start   = 1'b0;
    logic        pd_req  = 1'b0;
    logic        split   = 1'b0;
    logic [9:0]  temp_in = 10'h3FF;
    logic        busy, done, power_down, result_valid, converting, power_down_b;
    logic [15:0] rd_word, mon_word, got;
    logic [9:0]  rd_temp;
    logic [9:0]  dev_result;
    logic [9:0]  codes [4] = '{10'h200, 10'h1FC, 10'h000, 10'h1F4};
    int          mismatches = 0;
    int          tests_run  = 0;
    int          cycles     = 0;
    int          i;

    stp_if link_if ();
    stp_if fault_if ();

    stp_host stp_host_inst (.link(link_if.host), .ref_clk(ref_clk), .sys_rst(sys_rst), .start(start),
        .pd_req(pd_req), .split(split), .busy(busy), .done(done), .rd_word(rd_word), .rd_temp(rd_temp));
    stp_device #(.CONV_PERIOD_CYCLES(CONV_PERIOD)) stp_device_inst (.link(link_if.dev), .ref_clk(ref_clk),
        .sys_rst(sys_rst), .temp_in(temp_in), .temperature_result(dev_result), .power_down(power_down),
        .result_valid(result_valid), .converting(converting));
    stp_device #(.CONV_PERIOD_CYCLES(CONV_PERIOD)) stp_device_inst_b (.link(fault_if.dev), .ref_clk(ref_clk),
        .sys_rst(sys_rst), .temp_in(temp_in), .temperature_result(), .power_down(power_down_b),
        .result_valid(), .converting());
    stp_link_props stp_link_props_inst (.ref_clk(ref_clk), .sys_rst(sys_rst), .cs_n(link_if.cs_n),
        .sclk(link_if.sclk), .din(link_if.din), .dout_o(link_if.dout_o), .dout_oe(link_if.dout_oe),
        .dout_line(link_if.dout_line));

    always #4 ref_clk = ~ref_clk;

    // The line is sampled where the master samples it, independent of the master's shifter.
    always @(posedge link_if.sclk) begin
        if (!link_if.cs_n) begin
            mon_word <= {mon_word[14:0], link_if.dout_line};
        end
    end

    task automatic tally_and_finish();
        $display("compares %0d mismatches %0d", tests_run, mismatches);
        if (mismatches == 0 && tests_run > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask

    always @(posedge ref_clk) begin
        cycles++;
        if (cycles == TIME_LIMIT) begin
            mismatches++;
            tally_and_finish();
        end
    end

    task automatic chk(input logic [15:0] seen, input logic [15:0] expected);
        tests_run++;
        if (seen !== expected) begin
            mismatches++;
            $display("unexpected at %0t: seen %h expected %h", $time, seen, expected);
        end
    endtask

    task automatic host_frame(input logic pd, input logic spl);
        int n;
        n = 0;
        @(negedge ref_clk);
        start = 1'b1;
        pd_req = pd;
        split = spl;
        @(negedge ref_clk);
        start = 1'b0;
        chk({15'h0000, busy}, 16'h0001);
        while (done !== 1'b1 && n < 600) begin
            @(negedge ref_clk);
            n++;
        end
        chk({15'h0000, done}, 16'h0001);
        repeat (20) @(negedge ref_clk);
    endtask

    task automatic read_expect(input logic pd, input logic spl, input logic [9:0] t);
        host_frame(pd, spl);
        chk(rd_word, {t, 6'h00});
        chk(mon_word, {t, 6'h00});
        chk({6'h00, rd_temp}, {6'h00, t});
        chk({6'h00, dev_result}, {6'h00, t});
    endtask

    task automatic wait_conv();
        int n;
        n = 0;
        while (converting !== 1'b1 && n < 5000) begin
            @(negedge ref_clk);
            n++;
        end
        chk({15'h0000, converting}, 16'h0001);
        while (converting !== 1'b0 && n < 10000) begin
            @(negedge ref_clk);
            n++;
        end
        chk({15'h0000, converting}, 16'h0000);
    endtask

    // Bench-made link clock at 48 ns, offset from ref_clk, running inside the frame and toggled four more times after select is released.
    task automatic fault_frame(input logic [15:0] word, input int pulses);
        got = 16'h0000;
        @(negedge ref_clk);
        fault_if.cs_n = 1'b0;
        repeat (8) @(negedge ref_clk);
        #3;
        for (int k = 0; k < pulses; k++) begin
            fault_if.sclk = 1'b0;
            fault_if.din = word[15 - k];
            #24 fault_if.sclk = 1'b1;
            got[15 - k] = fault_if.dout_line;
            #24;
        end
        repeat (10) @(negedge ref_clk);
        fault_if.cs_n = 1'b1;
        fault_if.din = 1'b1;
        repeat (4) #24 fault_if.sclk = ~fault_if.sclk;
        fault_if.din = 1'b0;
        repeat (10) @(negedge ref_clk);
    endtask

    initial begin
        fault_if.cs_n = 1'b1;
        fault_if.sclk = 1'b1;
        fault_if.din = 1'b0;
        repeat (6) @(negedge ref_clk);
        sys_rst = 1'b0;
        wait_conv();
        chk({15'h0000, result_valid}, 16'h0001);
        read_expect(1'b0, 1'b0, 10'h3FF);
        $display("test first_read done");
        for (i = 0; i < 4; i++) begin
            temp_in = codes[i];
            wait_conv();
            read_expect(1'b0, i[0], codes[i]);
        end
        $display("test code_table done");
        wait_conv();
        host_frame(1'b1, 1'b0);
        chk({15'h0000, power_down}, 16'h0001);
        temp_in = 10'h064;
        repeat (CONV_PERIOD + 500) @(negedge ref_clk);
        chk({15'h0000, converting}, 16'h0000);
        read_expect(1'b1, 1'b0, 10'h1F4);
        host_frame(1'b0, 1'b0);
        chk({15'h0000, power_down}, 16'h0000);
        wait_conv();
        read_expect(1'b0, 1'b0, 10'h064);
        $display("test shutdown done");
        fault_frame(16'h0000, 16);
        chk(got, {10'h064, 6'h00});
        chk({15'h0000, power_down_b}, 16'h0000);
        // Clock edges given while deselected would shift this readout if they were not ignored.
        fault_frame(16'h2000, 10);
        chk({got[15:6], 6'h00}, {10'h064, 6'h00});
        chk({15'h0000, power_down_b}, 16'h0000);
        fault_frame(16'h2000, 16);
        chk(got, {10'h064, 6'h00});
        chk({15'h0000, power_down_b}, 16'h0001);
        $display("test direct_link done");
        tally_and_finish();
    end
endmodule // serial_temp_readout_port_tb
